/* sfc_pkg.sv */
package sfc_pkg;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int DATA_W     = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W      = 5;

   // ----------------------------------------------------------------
   // Register offsets on the CPU port
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_MODE    = 4'h0;
   localparam logic [3:0] ADDR_TX_DATA = 4'h6;
   localparam logic [3:0] ADDR_RX_DATA = 4'hc;
   localparam logic [7:0] MODE_RESET   = 8'h00;
   localparam logic [7:0] READ_ZERO    = 8'h00;

   // ----------------------------------------------------------------
   // Mode register fields
   // ----------------------------------------------------------------
   localparam int MODE_SYNC   = 7;
   localparam int MODE_CHAR7  = 6;
   localparam int MODE_PAR_EN = 5;
   localparam int MODE_ODD    = 4;
   localparam int MODE_STOP2  = 3;
   localparam int MODE_MP     = 2;
   localparam int MODE_PRE_HI = 1;
   localparam int MODE_PRE_LO = 0;
   localparam int MODE_PW_HI  = 6;
   localparam int MODE_PW_LO  = 3;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam logic [5:0] PRE_MASK_1  = 6'h00;
   localparam logic [5:0] PRE_MASK_4  = 6'h03;
   localparam logic [5:0] PRE_MASK_16 = 6'h0f;
   localparam logic [5:0] PRE_MASK_64 = 6'h3f;
   localparam logic [3:0] PHASE_LAST  = 4'hf;
   localparam logic [3:0] PHASE_MID   = 4'h7;
   localparam logic [7:0] IR_UNIT     = 8'h04;
   localparam logic [2:0] LAST_BIT_8  = 3'h7;
   localparam logic [2:0] LAST_BIT_7  = 3'h6;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_START = 3'b001,
      ST_DATA  = 3'b010,
      ST_EXTRA = 3'b011,
      ST_STOP  = 3'b100
   } sfc_frame_type;
endpackage

/* sfc_fifo.sv */
`timescale 1ns/10ps
module sfc_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16,
   parameter int CW    = 5
) (
   input  wire logic          sys_clk,
   input  wire logic          rst_n,
   input  wire logic          push,
   input  wire logic [W-1:0]  push_data,
   input  wire logic          pop,
   output logic      [W-1:0]  pop_data,
   output logic               full,
   output logic               empty,
   output logic      [CW-1:0] count
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   wire           push_ok = push && !full;
   wire           pop_ok  = pop && !empty;

   function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
      if (p == AW'(DEPTH - 1)) return '0;
      return p + 1'b1;
   endfunction

   assign full     = (count == CW'(DEPTH));
   assign empty    = (count == '0);
   assign pop_data = mem[rd_ptr];

   always_ff @(posedge sys_clk) begin
      if (push_ok) begin
         mem[wr_ptr] <= push_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push_ok) wr_ptr <= wrap_inc(wr_ptr);
         if (pop_ok) rd_ptr <= wrap_inc(rd_ptr);
         if (push_ok && !pop_ok) count <= count + 1'b1;
         else if (pop_ok && !push_ok) count <= count - 1'b1;
      end
   end

   property p_full_no_overwrite;
      @(posedge sys_clk) disable iff (!rst_n)
      full && push && !pop |=> count == $past(count) && full;
   endproperty
   a_full_no_overwrite: assert property (p_full_no_overwrite)
      else $error("push into full queue changed it");

   property p_empty_pop_safe;
      @(posedge sys_clk) disable iff (!rst_n)
      empty && pop && !push |=> empty && rd_ptr == $past(rd_ptr);
   endproperty
   a_empty_pop_safe: assert property (p_empty_pop_safe)
      else $error("pop from empty queue moved state");
endmodule

/* sfc_channel.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - Receive pin shifts in, configurable bit order
// - Receive queue sixteen bytes, read only
// - Receiver rearms right after storing byte
// - Empty receive read undefined, state kept
// - Full receive queue drops new characters
// - Empty shifter loads oldest queued byte
// - Transmit serially, gapless while queue nonempty
// - Transmit queue sixteen, full writes dropped
// - Transmit queue write only, reads harmless
// - Shifters never mapped for CPU access
// - Mode register cleared by reset, standby
// - Mode bit 7 selects clocked synchronous
// - Bit 6 picks seven bits, async only
// - Seven bit mode drops data bit 7
// - Bit 5 enables parity, async only
// - Bit 4 picks odd, else even parity
// - Bit 3 two stop bits, sync none
// - Receiver checks first stop bit only
// - Bit 2 multiprocessor format overrides parity
// - Bits 1:0 choose prescale 1/4/16/64
// - Infrared reuses bits 6:3 for pulse width
module sfc_channel
   import sfc_pkg::*;
(
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire logic                     module_standby,
   input  wire logic [3:0]               cpu_addr,
   input  wire logic                     cpu_wr,
   input  wire logic                     cpu_rd,
   input  wire logic [sfc_pkg::DATA_W-1:0] cpu_wdata,
   output logic      [sfc_pkg::DATA_W-1:0] cpu_rdata,
   input  wire logic                     tx_enable,
   input  wire logic                     rx_enable,
   input  wire logic                     msb_first,
   input  wire logic                     infrared_mode,
   input  wire logic [7:0]               bit_rate_div,
   input  wire logic                     mp_bit_tx,
   input  wire logic                     rx_pin,
   output logic                          tx_pin,
   output logic                          sck_out,
   output logic                          rx_parity_error,
   output logic                          rx_framing_error,
   output logic                          rx_mp_bit,
   output logic      [sfc_pkg::CNT_W-1:0] rx_fifo_count,
   output logic      [sfc_pkg::CNT_W-1:0] tx_fifo_count
);
   import sfc_pkg::*;

   // ----------------------------------------------------------------
   // Mode register and CPU port
   // ----------------------------------------------------------------
   logic [7:0] serial_format_mode;

   wire sel_mode = (cpu_addr == ADDR_MODE);
   wire sel_tx   = (cpu_addr == ADDR_TX_DATA);
   wire sel_rx   = (cpu_addr == ADDR_RX_DATA);

   // Writing the receive queue or reading the transmit queue does nothing
   wire tx_wr_req = cpu_wr && sel_tx;
   wire rx_rd_req = cpu_rd && sel_rx;

   wire sync_mode = serial_format_mode[MODE_SYNC] && !infrared_mode;
   wire char7     = serial_format_mode[MODE_CHAR7] && !sync_mode
                    && !infrared_mode;
   wire mp_on     = serial_format_mode[MODE_MP] && !sync_mode
                    && !infrared_mode;
   wire par_on    = serial_format_mode[MODE_PAR_EN] && !sync_mode
                    && !mp_on && !infrared_mode;
   wire odd_par   = serial_format_mode[MODE_ODD];
   wire stop2     = serial_format_mode[MODE_STOP2] && !infrared_mode;
   wire extra_on  = par_on || mp_on;
   wire [3:0] pw_sel = serial_format_mode[MODE_PW_HI:MODE_PW_LO];
   wire [1:0] pre_sel = serial_format_mode[MODE_PRE_HI:MODE_PRE_LO];

   always_ff @(posedge sys_clk) begin
      if (!rst_n || module_standby) begin
         serial_format_mode <= MODE_RESET;
      end else if (cpu_wr && sel_mode) begin
         serial_format_mode <= cpu_wdata;
      end
   end

   logic [7:0] rx_head;

   // Shifters have no address, so no read path reaches them
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cpu_rdata <= READ_ZERO;
      end else if (cpu_rd) begin
         if (sel_mode) cpu_rdata <= serial_format_mode;
         else if (sel_rx) cpu_rdata <= rx_head;
         else cpu_rdata <= READ_ZERO;
      end
   end

   // ----------------------------------------------------------------
   // Baud generator: prescale, then divide to sixteen ticks per bit
   // ----------------------------------------------------------------
   logic [5:0] pre_cnt;
   logic [7:0] div_cnt;
   logic       tick;
   wire  [5:0] pre_mask = (pre_sel == 2'h0) ? PRE_MASK_1 :
                          (pre_sel == 2'h1) ? PRE_MASK_4 :
                          (pre_sel == 2'h2) ? PRE_MASK_16 : PRE_MASK_64;
   wire        pre_tick = ((pre_cnt & pre_mask) == pre_mask);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pre_cnt <= '0;
         div_cnt <= '0;
         tick    <= 1'b0;
      end else begin
         pre_cnt <= pre_cnt + 1'b1;
         tick    <= pre_tick && (div_cnt == '0);
         if (pre_tick) div_cnt <= (div_cnt == '0) ? bit_rate_div : div_cnt - 1'b1;
      end
   end

   function automatic logic [2:0] bit_index(input logic [2:0] cnt, input logic msb,
                                            input logic c7);
      if (!msb) return cnt;
      if (c7) return LAST_BIT_7 - cnt;
      return LAST_BIT_8 - cnt;
   endfunction

   wire [2:0] last_bit = char7 ? LAST_BIT_7 : LAST_BIT_8;

   // ----------------------------------------------------------------
   // Receive path
   // ----------------------------------------------------------------
   logic          rx_meta;
   logic          rx_s;
   sfc_frame_type rx_state;
   logic [3:0]    rx_phase;
   logic [2:0]    rx_cnt;
   logic [7:0]    receive_shifter;
   logic          rx_extra;
   logic          rx_full;
   logic          rx_empty;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rx_meta <= 1'b1;
         rx_s    <= 1'b1;
      end else begin
         rx_meta <= rx_pin;
         rx_s    <= rx_meta;
      end
   end

   // Infrared pulses mark zero bits
   wire       rx_bit    = infrared_mode ? !rx_s : rx_s;
   wire       rx_sample = tick && (rx_phase == PHASE_LAST);
   wire [2:0] rx_idx    = bit_index(rx_cnt, msb_first, char7);
   wire       rx_data_last = rx_sample && (rx_state == ST_DATA) && (rx_cnt == last_bit);
   wire       rx_stop_done = rx_sample && (rx_state == ST_STOP);
   wire       rx_par_bad   = par_on && ((^receive_shifter) ^ rx_extra ^ odd_par);

   logic [7:0] rx_word;
   always_comb begin
      rx_word = receive_shifter;
      if (sync_mode) rx_word[rx_idx] = rx_bit;
   end

   wire rx_push = (sync_mode && rx_data_last) || (!sync_mode && rx_stop_done);

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !rx_enable) begin
         rx_state        <= ST_IDLE;
         rx_phase        <= '0;
         rx_cnt          <= '0;
         receive_shifter <= '0;
         rx_extra        <= 1'b0;
      end else begin
         if (tick) rx_phase <= rx_phase + 1'b1;
         unique case (rx_state)
            ST_IDLE: begin
               rx_phase        <= '0;
               rx_cnt          <= '0;
               receive_shifter <= '0;
               if (sync_mode) rx_state <= ST_DATA;
               else if (!rx_bit) rx_state <= ST_START;
            end
            ST_START: begin
               if (tick && rx_phase == PHASE_MID) begin
                  rx_phase <= '0;
                  rx_state <= rx_bit ? ST_IDLE : ST_DATA;
               end
            end
            ST_DATA: begin
               if (rx_sample) begin
                  receive_shifter[rx_idx] <= rx_bit;
                  rx_cnt <= rx_cnt + 1'b1;
                  if (rx_cnt == last_bit) begin
                     rx_cnt <= '0;
                     if (sync_mode) receive_shifter <= '0;
                     else rx_state <= extra_on ? ST_EXTRA : ST_STOP;
                  end
               end
            end
            ST_EXTRA: begin
               if (rx_sample) begin
                  rx_extra <= rx_bit;
                  rx_state <= ST_STOP;
               end
            end
            // Only the first stop bit is looked at; a low second one starts a frame
            ST_STOP: begin
               if (rx_sample) rx_state <= ST_IDLE;
            end
            default: rx_state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rx_parity_error  <= 1'b0;
         rx_framing_error <= 1'b0;
         rx_mp_bit        <= 1'b0;
      end else if (rx_stop_done) begin
         rx_framing_error <= !rx_bit;
         rx_parity_error  <= rx_par_bad;
         rx_mp_bit        <= mp_on && rx_extra;
      end
   end

   // Full queue refuses the push, so the character is lost
   sfc_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_rx_fifo (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .push      (rx_push),
      .push_data (rx_word),
      .pop       (rx_rd_req),
      .pop_data  (rx_head),
      .full      (rx_full),
      .empty     (rx_empty),
      .count     (rx_fifo_count)
   );

   // ----------------------------------------------------------------
   // Transmit path
   // ----------------------------------------------------------------
   sfc_frame_type tx_state;
   logic [3:0]    tx_phase;
   logic [2:0]    tx_cnt;
   logic [7:0]    transmit_shifter;
   logic [7:0]    tx_head;
   logic          tx_full;
   logic          tx_empty;
   logic [7:0]    ir_cnt;

   wire       tx_bit_end = tick && (tx_phase == PHASE_LAST);
   wire [2:0] tx_idx     = bit_index(tx_cnt, msb_first, char7);
   wire       tx_par_bit = (^transmit_shifter) ^ odd_par;
   wire       tx_last_bit =
      tx_bit_end && ((tx_state == ST_STOP && (tx_cnt == '0) == !stop2) ||
                     (tx_state == ST_DATA && sync_mode && tx_cnt == LAST_BIT_8));
   wire       tx_load = tx_enable && !tx_empty &&
                        (tx_state == ST_IDLE || tx_last_bit);
   wire [7:0] tx_load_data = char7 ? {1'b0, tx_head[6:0]} : tx_head;

   logic tx_level;
   always_comb begin
      unique case (tx_state)
         ST_START: tx_level = 1'b0;
         ST_DATA:  tx_level = transmit_shifter[tx_idx];
         ST_EXTRA: tx_level = mp_on ? mp_bit_tx : tx_par_bit;
         default:  tx_level = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tx_state         <= ST_IDLE;
         tx_phase         <= '0;
         tx_cnt           <= '0;
         transmit_shifter <= '0;
      end else if (tx_load) begin
         tx_state         <= sync_mode ? ST_DATA : ST_START;
         tx_phase         <= '0;
         tx_cnt           <= '0;
         transmit_shifter <= tx_load_data;
      end else if (tx_last_bit || (tx_state == ST_IDLE)) begin
         tx_state <= ST_IDLE;
         tx_phase <= '0;
      end else begin
         if (tick) tx_phase <= tx_phase + 1'b1;
         if (tx_bit_end) begin
            unique case (tx_state)
               ST_START: tx_state <= ST_DATA;
               ST_DATA: begin
                  tx_cnt <= tx_cnt + 1'b1;
                  if (tx_cnt == last_bit) begin
                     tx_cnt   <= '0;
                     tx_state <= extra_on ? ST_EXTRA : ST_STOP;
                  end
               end
               ST_EXTRA: tx_state <= ST_STOP;
               ST_STOP:  tx_cnt <= tx_cnt + 1'b1;
               default:  tx_state <= ST_IDLE;
            endcase
         end
      end
   end

   // Infrared: a zero bit becomes a short high pulse at its start
   wire [7:0] ir_width = 8'((pw_sel + 5'h01) * IR_UNIT);
   wire       bit_start = tx_load || tx_bit_end;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ir_cnt  <= '0;
         tx_pin  <= 1'b1;
         sck_out <= 1'b1;
      end else begin
         if (bit_start) ir_cnt <= '0;
         else if (ir_cnt != 8'hff) ir_cnt <= ir_cnt + 1'b1;
         tx_pin  <= infrared_mode ? (!tx_level && ir_cnt < ir_width) : tx_level;
         sck_out <= !(sync_mode && tx_state == ST_DATA) || tx_phase[3];
      end
   end

   sfc_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_tx_fifo (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .push      (tx_wr_req),
      .push_data (cpu_wdata),
      .pop       (tx_load),
      .pop_data  (tx_head),
      .full      (tx_full),
      .empty     (tx_empty),
      .count     (tx_fifo_count)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_mode_standby;
      @(posedge sys_clk) disable iff (!rst_n)
      module_standby |=> serial_format_mode == MODE_RESET;
   endproperty
   a_mode_standby: assert property (p_mode_standby)
      else $error("mode register not cleared by standby");

   property p_mode_write;
      @(posedge sys_clk) disable iff (!rst_n)
      cpu_wr && sel_mode && !module_standby |=> serial_format_mode == $past(cpu_wdata);
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("mode register write lost");

   property p_tx_full_drop;
      @(posedge sys_clk) disable iff (!rst_n)
      tx_wr_req && tx_full && !tx_load |=> tx_fifo_count == $past(tx_fifo_count);
   endproperty
   a_tx_full_drop: assert property (p_tx_full_drop)
      else $error("write to full transmit queue accepted");

   property p_tx_read_harmless;
      @(posedge sys_clk) disable iff (!rst_n)
      cpu_rd && sel_tx && !tx_wr_req && !tx_load |=> $stable(tx_fifo_count);
   endproperty
   a_tx_read_harmless: assert property (p_tx_read_harmless)
      else $error("read of transmit queue altered it");

   sequence s_async_load;
      tx_load && !sync_mode && !infrared_mode;
   endsequence
   property p_tx_start_bit;
      @(posedge sys_clk) disable iff (!rst_n)
      s_async_load ##1 !infrared_mode |-> ##1 !tx_pin;
   endproperty
   a_tx_start_bit: assert property (p_tx_start_bit)
      else $error("start bit not driven after load");

   property p_two_stops;
      @(posedge sys_clk) disable iff (!rst_n)
      tx_state == ST_STOP && tx_cnt == '0 && tx_bit_end && stop2 && !tx_load
      |=> tx_state == ST_STOP && tx_cnt == 3'h1;
   endproperty
   a_two_stops: assert property (p_two_stops)
      else $error("second stop bit missing");

   property p_sync_no_frame;
      @(posedge sys_clk) disable iff (!rst_n)
      sync_mode && tx_load |=> tx_state == ST_DATA;
   endproperty
   a_sync_no_frame: assert property (p_sync_no_frame)
      else $error("sync frame began with start bit");

   property p_rx_rearm;
      @(posedge sys_clk) disable iff (!rst_n || !rx_enable)
      rx_stop_done && !sync_mode |=> rx_state == ST_IDLE;
   endproperty
   a_rx_rearm: assert property (p_rx_rearm)
      else $error("receiver not rearmed after stop");

   property p_char7_bit7;
      @(posedge sys_clk) disable iff (!rst_n)
      tx_load && char7 |=> !transmit_shifter[7];
   endproperty
   a_char7_bit7: assert property (p_char7_bit7)
      else $error("bit 7 kept in seven bit mode");
endmodule

/* sfc_peer.sv */
`timescale 1ns/10ps
module sfc_peer (
   input  wire logic sys_clk,
   input  wire logic tx_pin,
   output logic      rx_pin
);
   int         bit_cycles;
   logic [8:0] got_q[$];
   initial begin
      rx_pin = 1'b1;
      bit_cycles = 16;
   end
   // -------------------------------------------------------
   // Start bit then nine bits, lowest first; line idles high
   // -------------------------------------------------------
   task automatic send(input logic [8:0] f);
      @(negedge sys_clk);
      rx_pin = 1'b0;
      repeat (bit_cycles) @(negedge sys_clk);
      for (int i = 0; i < 9; i++) begin
         rx_pin = f[i];
         repeat (bit_cycles) @(negedge sys_clk);
      end
      rx_pin = 1'b1;
   endtask
   // Nine samples at bit centres after each falling start edge
   initial begin
      logic [8:0] f;
      forever begin
         @(negedge tx_pin);
         repeat (bit_cycles / 2) @(posedge sys_clk);
         for (int i = 0; i < 9; i++) begin
            repeat (bit_cycles) @(posedge sys_clk);
            f[i] = tx_pin;
         end
         got_q.push_back(f);
      end
   end
endmodule

/* serial_fifo_datapath_and_mode_test.sv */
`timescale 1ns/10ps
module serial_fifo_datapath_and_mode_test;
   import sfc_pkg::*;
   logic       sys_clk, rst_n, module_standby, cpu_wr, cpu_rd, tx_enable, rx_enable;
   logic       msb_first, infrared_mode, mp_bit_tx, rx_pin, tx_pin, sck_out;
   logic       rx_parity_error, rx_framing_error, rx_mp_bit;
   logic [3:0] cpu_addr;
   logic [7:0] cpu_wdata, cpu_rdata, bit_rate_div, d, m;
   logic [4:0] rx_fifo_count, tx_fifo_count;
   logic [8:0] q[$];
   int         mismatches, checks;

   sfc_channel sfc_channel_i (.sys_clk, .rst_n, .module_standby, .cpu_addr, .cpu_wr, .cpu_rd,
      .cpu_wdata, .cpu_rdata, .tx_enable, .rx_enable, .msb_first, .infrared_mode,
      .bit_rate_div, .mp_bit_tx, .rx_pin, .tx_pin, .sck_out, .rx_parity_error,
      .rx_framing_error, .rx_mp_bit, .rx_fifo_count, .tx_fifo_count);
   sfc_peer sfc_peer_i (.sys_clk, .tx_pin, .rx_pin);

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // -------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------
   task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(negedge sys_clk);
      cpu_addr = a;
      cpu_wdata = v;
      cpu_wr = 1'b1;
      @(negedge sys_clk);
      cpu_wr = 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(negedge sys_clk);
      cpu_addr = a;
      cpu_rd = 1'b1;
      @(negedge sys_clk);
      cpu_rd = 1'b0;
      v = cpu_rdata;
   endtask
   task automatic await_tx(input int n);
      for (int k = 0; k < 30000 && sfc_peer_i.got_q.size() < n; k++) @(posedge sys_clk);
      check(9'(sfc_peer_i.got_q.size()), 9'(n), "frames seen");
   endtask
   function automatic logic [8:0] frame(input logic [7:0] v, input logic [7:0] md,
                                        input logic msb);
      if (md[MODE_CHAR7]) return {1'b1, ^v[6:0] ^ md[MODE_ODD], v[6:0]};
      return {1'b1, msb ? 8'({<<{v}}) : v};
   endfunction
   task report_and_stop;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk);
      mismatches++;
      report_and_stop;
   end
   // -------------------------------------------------------
   // Tests
   // -------------------------------------------------------
   initial begin
      {rst_n, module_standby, cpu_wr, cpu_rd, tx_enable, rx_enable} = '0;
      {msb_first, infrared_mode, mp_bit_tx, cpu_addr, cpu_wdata, bit_rate_div} = '0;
      void'($urandom(32'h6a513222));
      repeat (20) @(negedge sys_clk);
      rst_n = 1'b1;
      rd(ADDR_MODE, d); check(d, MODE_RESET, "mode reset");
      m = 8'($urandom);
      wr(ADDR_MODE, m); rd(ADDR_MODE, d); check(d, m, "mode rw");
      @(negedge sys_clk) module_standby = 1'b1;
      @(negedge sys_clk) module_standby = 1'b0;
      rd(ADDR_MODE, d); check(d, MODE_RESET, "mode standby");
      rd(ADDR_TX_DATA, d); check(d, READ_ZERO, "tx read");
      wr(ADDR_RX_DATA, 8'h5a); check(rx_fifo_count, 0, "rx write");
      rd(ADDR_RX_DATA, d); check(rx_fifo_count, 0, "rx empty read");
      $display("test registers done");
      rx_enable = 1'b1;
      for (int i = 0; i < 17; i++) begin
         d = 8'($urandom);
         if (i < 16) q.push_back({1'b0, d});
         sfc_peer_i.send(frame(d, 8'h00, 1'b0));
      end
      check(rx_fifo_count, 16, "rx full");
      for (int i = 0; i < 16; i++) begin
         rd(ADDR_RX_DATA, d); check(d, q.pop_front(), "rx data");
      end
      msb_first = 1'b1;
      sfc_peer_i.send(frame(8'hc5, 8'h00, 1'b1));
      rd(ADDR_RX_DATA, d); check(d, 8'hc5, "rx msb first");
      msb_first = 1'b0;
      for (int j = 0; j < 2; j++) begin
         m = j ? 8'h70 : 8'h60;
         wr(ADDR_MODE, m);
         d = 8'($urandom);
         sfc_peer_i.send(frame(d, m, 1'b0));
         check(rx_parity_error, 0, "parity good");
         check(rx_framing_error, 0, "stop good");
         sfc_peer_i.send(frame(d, m, 1'b0) ^ 9'h080);
         check(rx_parity_error, 1, "parity bad");
      end
      // Low stop bit; the receiver is then parked so a false start cannot linger
      sfc_peer_i.send(frame(d, m, 1'b0) ^ 9'h100);
      check(rx_framing_error, 1, "stop bad");
      rx_enable = 1'b0;
      $display("test receive done");
      wr(ADDR_MODE, 8'h00);
      msb_first = 1'b1;
      for (int i = 0; i < 17; i++) begin
         d = 8'($urandom);
         if (i < 16) q.push_back(frame(d, 8'h00, 1'b1));
         wr(ADDR_TX_DATA, d);
      end
      check(tx_fifo_count, 16, "tx full");
      rd(ADDR_TX_DATA, d); check(tx_fifo_count, 16, "tx read kept");
      tx_enable = 1'b1;
      await_tx(16);
      while (q.size() > 0) check(sfc_peer_i.got_q.pop_front(), q.pop_front(), "tx");
      msb_first = 1'b0;
      for (int i = 0; i < 5; i++) begin
         m = (i < 2) ? (i ? 8'h70 : 8'h60) : 8'(i - 1);
         sfc_peer_i.bit_cycles = 16 << (2 * ((i < 2) ? 0 : i - 1));
         d = 8'($urandom);
         wr(ADDR_MODE, m);
         wr(ADDR_TX_DATA, d);
         await_tx(1);
         check(sfc_peer_i.got_q.pop_front(), frame(d, m, 1'b0), "tx format");
      end
      $display("test transmit done");
      report_and_stop;
   end
endmodule
